// file: plc_defs.vh
// Purpose: shared constants for the attach detection and wet contact measurement sequencer
// Assumes: 200 MHz mclk; offsets are byte addresses on the plain register port
// Notes: times are kept in ms and converted to cycles inside the module
`ifndef PLC_DEFS_VH
`define PLC_DEFS_VH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_CONFIG 8'h04
`define REG_STATUS 8'h08
`define REG_FLAGS 8'h0c
`define REG_RESULT 8'h10

// ---------------------------------------------------------------
// field layout and reset values
// ---------------------------------------------------------------
`define CTRL_MANUAL 0
`define CFG_THR_LO 0
`define CFG_THR_HI 9
`define CFG_TGT_LO 16
`define CFG_TGT_HI 17
`define CFG_RNG_LO 24
`define CFG_RNG_HI 29
`define THR_RESET 10'h2bc
`define TGT_RESET 2'h0
`define RNG_RESET 6'h00
`define FLAG_LINK 0
`define FLAG_DEAD 1
`define FLAG_GND 2
`define FLAG_WET 3
`define FLAG_DONE 4
`define FLAG_OPEN 5
`define FLAG_ABORT 6
`define FLAG_W 7
`define RES_CUR_LO 8
`define RES_CUR_HI 14

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_KHZ 32'd200000
`define T_PULSE_MS 32'd240
`define T_POWER_MS 32'd200
`define T_AUTO_MS 32'd16000

// ---------------------------------------------------------------
// measurement
// ---------------------------------------------------------------
`define ADC_FULL 6'h3f
`define REDUCED_LIMIT 2'h3
`define CUR_MAX_IDX 2'h3
`define SMP_LAST 2'h3
`define AVG_SHIFT 2
`define ABORT_SPAN 6'h08
`define GND_OHM 40'd458
`define OPEN_OHM 40'd1500000
`define MV_TO_UV 40'd1000
`define LSB_UV_DEF 20'd20000

`endif

// file: wet_classify.v
// Purpose: sorts a finished measurement into ground short, wet, done and open
// Assumes: resistance = reading * lsb / current, compared by cross products
// Notes: one cycle from start to valid; ground short also reports wet
`timescale 1ns/100ps
`include "plc_defs.vh"
module wet_classify #(
   parameter [19:0] LSB_UV = `LSB_UV_DEF
)(
   // clock and control
   input wire mclk,
   input wire rst,
   input wire ce,
   input wire start,
   // measurement
   input wire [5:0] avg,
   input wire [6:0] cur_ua,
   input wire [9:0] thr_mv,
   input wire [6:0] tgt_ua,
   // result
   output reg valid,
   output reg is_gnd,
   output reg is_wet,
   output reg is_done,
   output reg is_open
);
   // reading scaled to microvolts; 40 bits keep every product exact
   wire [39:0] v_uv = {34'd0, avg} * {20'd0, LSB_UV};
   wire [39:0] cur40 = {33'd0, cur_ua};
   wire [39:0] lhs_wet = v_uv * {33'd0, tgt_ua};
   wire [39:0] rhs_wet = {30'd0, thr_mv} * `MV_TO_UV * cur40;
   wire wet = lhs_wet < rhs_wet;
   wire gnd = v_uv < `GND_OHM * cur40;
   wire open = v_uv > `OPEN_OHM * cur40;

   // registered verdict
   always @(posedge mclk)
   begin
      if (rst)
      begin
         valid <= 1'b0;
         is_gnd <= 1'b0;
         is_wet <= 1'b0;
         is_done <= 1'b0;
         is_open <= 1'b0;
      end
      else if (ce)
      begin
         valid <= start;
         if (start)
         begin
            is_gnd <= gnd;
            is_wet <= wet;
            is_done <= !wet && !open;
            is_open <= open;
         end
      end
   end
endmodule // wet_classify

// file: plc_attach_moisture_detect.v
// Purpose: slave side attach detection, wet contact measurement and retry sequencer
// Assumes: pulse comparator and line power inputs are asynchronous pins; adc is on mclk
// Notes: sticky flags clear by writing one; a set in the same cycle wins
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "plc_defs.vh"
module plc_attach_moisture_detect #(
   parameter [31:0] PULSE_CYC = `T_PULSE_MS * `CLK_KHZ,
   parameter [31:0] POWER_CYC = `T_POWER_MS * `CLK_KHZ,
   parameter [31:0] AUTO_CYC = `T_AUTO_MS * `CLK_KHZ,
   parameter [19:0] LSB_UV = `LSB_UV_DEF
)(
   // clock, reset, enable
   input wire mclk,
   input wire rst,
   input wire ce,
   // register port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   // detection pulse front end
   output reg pulse_fire,
   input wire pulse_done_in,
   input wire pulse_reduced_in,
   input wire line_power_in,
   // link state from the link controller
   input wire link_up,
   // adc and current source
   output reg adc_start,
   output reg [1:0] source_current_idx,
   output reg source_on,
   input wire adc_done,
   input wire [5:0] adc_data
);
   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_START = 3'd1;
   localparam [2:0] ST_WAIT = 3'd2;
   localparam [2:0] ST_STEP = 3'd3;
   localparam [2:0] ST_CLASS = 3'd4;
   localparam [2:0] ST_LINK = 3'd5;

   // source current in uA for a step index: 1, 4, 16, 64
   function [6:0] idx_to_ua;
      input [1:0] idx;
      begin
         idx_to_ua = 7'h01 << {idx, 1'b0};
      end
   endfunction

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   reg [2:0] state;
   reg [9:0] wet_voltage_threshold;
   reg [1:0] target_source_current_sel;
   reg [5:0] adc_range_offset;
   reg [5:0] averaged_adc_reading;
   reg [6:0] applied_source_current;
   reg [`FLAG_W-1:0] flags;
   reg meas_req;
   reg pend_manual;
   reg wet_present;
   reg [1:0] reduced_cnt;
   reg [31:0] pulse_cnt;
   reg [31:0] power_cnt;
   reg power_armed;
   reg [31:0] auto_cnt;
   reg [1:0] smp;
   reg [7:0] sum;
   reg [5:0] smp_min;
   reg [5:0] smp_max;
   reg link_d;
   reg cls_start;
   // pin synchronisers; stage one feeds stage two only
   reg done_s1, done_s2, done_s3;
   reg red_s1, red_s2;
   reg pwr_s1, pwr_s2;

   wire cls_valid, cls_gnd, cls_wet, cls_done, cls_open;
   wire pulse_result = done_s2 && !done_s3;
   wire [5:0] cur_avg = sum[`AVG_SHIFT+5:`AVG_SHIFT];
   wire [5:0] step_limit = `ADC_FULL - adc_range_offset;
   wire [5:0] spread = smp_max - smp_min;
   wire man_wr = wr && (addr == `REG_CTRL) && wdata[`CTRL_MANUAL];
   wire clr_wr = wr && (addr == `REG_FLAGS);
   wire link_fall = link_d && !link_up;
   wire link_rise = link_up && !link_d;
   wire busy = (state != ST_IDLE) && (state != ST_LINK);

   // ---------------------------------------------------------------
   // verdict
   // ---------------------------------------------------------------
   wet_classify #(
      .LSB_UV(LSB_UV)
   ) u_classify (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .start(cls_start),
      .avg(averaged_adc_reading),
      .cur_ua(applied_source_current),
      .thr_mv(wet_voltage_threshold),
      .tgt_ua(idx_to_ua(target_source_current_sel)),
      .valid(cls_valid),
      .is_gnd(cls_gnd),
      .is_wet(cls_wet),
      .is_done(cls_done),
      .is_open(cls_open)
   );

   // two flops on each pin before any logic looks at it
   always @(posedge mclk)
   begin
      if (rst)
      begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_s3 <= 1'b0;
         red_s1 <= 1'b0;
         red_s2 <= 1'b0;
         pwr_s1 <= 1'b0;
         pwr_s2 <= 1'b0;
         link_d <= 1'b0;
      end
      else if (ce)
      begin
         done_s1 <= pulse_done_in;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
         red_s1 <= pulse_reduced_in;
         red_s2 <= red_s1;
         pwr_s1 <= line_power_in;
         pwr_s2 <= pwr_s1;
         link_d <= link_up;
      end
   end

   // configuration writes
   always @(posedge mclk)
   begin
      if (rst)
      begin
         wet_voltage_threshold <= `THR_RESET;
         target_source_current_sel <= `TGT_RESET;
         adc_range_offset <= `RNG_RESET;
      end
      else if (ce && wr && addr == `REG_CONFIG)
      begin
         wet_voltage_threshold <= wdata[`CFG_THR_HI:`CFG_THR_LO];
         target_source_current_sel <= wdata[`CFG_TGT_HI:`CFG_TGT_LO];
         adc_range_offset <= wdata[`CFG_RNG_HI:`CFG_RNG_LO];
      end
   end

   // read data stand only in the cycle after the strobe
   always @(posedge mclk)
   begin
      if (rst)
         rdata <= 32'h0000_0000;
      else if (ce)
      begin
         rdata <= 32'h0000_0000;
         if (rd)
         begin
            case (addr)
               `REG_CONFIG:
                  rdata <= {2'h0, adc_range_offset, 6'h00, target_source_current_sel,
                     6'h00, wet_voltage_threshold};
               `REG_STATUS:
                  rdata <= {24'h0, 1'b0, state, wet_present, pend_manual, busy, link_up};
               `REG_FLAGS:
                  rdata <= {25'h0, flags};
               `REG_RESULT:
                  rdata <= {17'h0, applied_source_current, 2'h0, averaged_adc_reading};
               default:
                  rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // pulse timing, attach detection and retry timers
   // ---------------------------------------------------------------
   // pulse and retry timers are held at zero and the power watchdog disarmed in link mode since the line is then powered and regulated
   always @(posedge mclk)
   begin
      if (rst)
      begin
         pulse_cnt <= 32'h0000_0000;
         pulse_fire <= 1'b0;
         reduced_cnt <= 2'h0;
         power_cnt <= 32'h0000_0000;
         power_armed <= 1'b0;
         auto_cnt <= 32'h0000_0000;
         pend_manual <= 1'b0;
         meas_req <= 1'b0;
      end
      else if (ce)
      begin
         pulse_fire <= 1'b0;
         if (link_up)
         begin
            pulse_cnt <= 32'h0000_0000;
            auto_cnt <= 32'h0000_0000;
            power_armed <= 1'b0;
         end
         else
         begin
            // pulses continue while wet or waiting, only paused during a measurement
            if (pulse_cnt == PULSE_CYC - 32'd1)
            begin
               pulse_cnt <= 32'h0000_0000;
               pulse_fire <= !busy;
            end
            else
               pulse_cnt <= pulse_cnt + 32'd1;
            // periodic retry always runs; no bit can switch it off
            if (auto_cnt == AUTO_CYC - 32'd1)
            begin
               auto_cnt <= 32'h0000_0000;
               meas_req <= 1'b1;
            end
            else
               auto_cnt <= auto_cnt + 32'd1;
            // power watchdog after detection
            if (power_armed)
            begin
               if (pwr_s2)
                  power_armed <= 1'b0;
               else if (power_cnt == POWER_CYC - 32'd1)
               begin
                  power_armed <= 1'b0;
                  meas_req <= 1'b1;
               end
               else
                  power_cnt <= power_cnt + 32'd1;
            end
         end
         // reduced pulse means less than 17k to ground
         if (pulse_result)
         begin
            if (red_s2)
            begin
               if (reduced_cnt == `REDUCED_LIMIT - 2'h1)
               begin
                  meas_req <= 1'b1;
                  power_armed <= 1'b1;
                  power_cnt <= 32'h0000_0000;
               end
               if (reduced_cnt != `REDUCED_LIMIT)
                  reduced_cnt <= reduced_cnt + 2'h1;
            end
            else
               reduced_cnt <= 2'h0;
         end
         // manual request is held while the link is up
         if (man_wr && link_up)
            pend_manual <= 1'b1;
         else if (man_wr)
            meas_req <= 1'b1;
         if (link_fall && pend_manual)
         begin
            pend_manual <= 1'b0;
            meas_req <= 1'b1;
         end
         // request is consumed when the sequencer picks it up
         if (state == ST_IDLE && !link_up && meas_req)
            meas_req <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // measurement sequencer and sticky flags
   // ---------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
         adc_start <= 1'b0;
         source_current_idx <= 2'h0;
         source_on <= 1'b0;
         smp <= 2'h0;
         sum <= 8'h00;
         smp_min <= `ADC_FULL;
         smp_max <= 6'h00;
         averaged_adc_reading <= 6'h00;
         applied_source_current <= 7'h00;
         cls_start <= 1'b0;
         wet_present <= 1'b0;
         flags <= {`FLAG_W{1'b0}};
      end
      else if (ce)
      begin
         adc_start <= 1'b0;
         cls_start <= 1'b0;
         // clear first so any set below in this cycle wins
         if (clr_wr)
            flags <= flags & ~wdata[`FLAG_W-1:0];
         if (link_rise)
            flags[`FLAG_LINK] <= 1'b1;
         if (pulse_result && red_s2 && reduced_cnt == `REDUCED_LIMIT - 2'h1)
            flags[`FLAG_DEAD] <= 1'b1;
         if (pulse_result && !red_s2 && wet_present && !busy)
         begin
            wet_present <= 1'b0;
            flags[`FLAG_WET] <= 1'b0;
         end
         case (state)
            ST_IDLE:
            begin
               if (link_up)
                  state <= ST_LINK;
               else if (meas_req)
               begin
                  source_current_idx <= 2'h0;
                  source_on <= 1'b1;
                  smp <= 2'h0;
                  sum <= 8'h00;
                  smp_min <= `ADC_FULL;
                  smp_max <= 6'h00;
                  state <= ST_START;
               end
            end
            ST_START:
            begin
               adc_start <= 1'b1;
               state <= ST_WAIT;
            end
            ST_WAIT:
            begin
               if (adc_done)
               begin
                  sum <= sum + {2'h0, adc_data};
                  if (adc_data < smp_min)
                     smp_min <= adc_data;
                  if (adc_data > smp_max)
                     smp_max <= adc_data;
                  smp <= smp + 2'h1;
                  state <= (smp == `SMP_LAST) ? ST_STEP : ST_START;
               end
            end
            ST_STEP:
            begin
               smp <= 2'h0;
               sum <= 8'h00;
               smp_min <= `ADC_FULL;
               smp_max <= 6'h00;
               averaged_adc_reading <= cur_avg;
               applied_source_current <= idx_to_ua(source_current_idx);
               if (spread > `ABORT_SPAN)
               begin
                  flags[`FLAG_ABORT] <= 1'b1;
                  source_on <= 1'b0;
                  state <= ST_IDLE;
               end
               else if (cur_avg < step_limit && source_current_idx != `CUR_MAX_IDX)
               begin
                  source_current_idx <= source_current_idx + 2'h1;
                  state <= ST_START;
               end
               else
               begin
                  source_on <= 1'b0;
                  cls_start <= 1'b1;
                  state <= ST_CLASS;
               end
            end
            ST_CLASS:
            begin
               if (cls_valid)
               begin
                  wet_present <= cls_wet;
                  if (cls_gnd)
                     flags[`FLAG_GND] <= 1'b1;
                  if (cls_wet)
                     flags[`FLAG_WET] <= 1'b1;
                  if (cls_done)
                     flags[`FLAG_DONE] <= 1'b1;
                  if (cls_open)
                     flags[`FLAG_OPEN] <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_LINK:
            begin
               if (!link_up)
                  state <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end
endmodule // plc_attach_moisture_detect

// file: plc_props.sv
// Purpose: port checker for the attach and wet measurement sequencer
// Assumes: ce held high; one clock domain
// Notes: pulse spacing checked as a multiple, since ticks in a measurement are skipped
`timescale 1ns/100ps
module plc_props #(
   parameter [31:0] PULSE_CYC = 32'd200
)(
   // clock and reset
   input wire mclk,
   input wire rst,
   // watched ports
   input wire link_up,
   input wire rd,
   input wire [31:0] rdata,
   input wire pulse_fire,
   input wire adc_start,
   input wire adc_done,
   input wire source_on,
   input wire [1:0] source_current_idx
);
   reg [31:0] gap;
   reg seen;
   // cycles since the last detection pulse; the link restarts the pulse timer,
   // so spacing is judged again only from the first pulse after it drops
   always @(posedge mclk)
   begin
      if (rst || link_up)
      begin
         gap <= 32'h0;
         seen <= 1'b0;
      end
      else if (pulse_fire)
      begin
         gap <= 32'h1;
         seen <= 1'b1;
      end
      else
         gap <= gap + 32'h1;
   end
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (rst);
   // a measurement opens at the lowest current, then converts
   sequence meas_begin;
      $rose(source_on);
   endsequence
   sequence first_conv;
      source_current_idx == 2'h0 ##1 adc_start;
   endsequence
   pulse_single_a: assert property (pulse_fire |=> !pulse_fire)
      else $error("pulse longer than one cycle");
   pulse_period_a: assert property (pulse_fire && seen |-> gap % PULSE_CYC == 32'h0)
      else $error("pulse spacing off");
   meas_open_a: assert property (meas_begin |-> first_conv)
      else $error("measurement opened wrongly");
   conv_single_a: assert property (adc_start |=> !adc_start)
      else $error("conversion start too long");
   conv_powered_a: assert property (adc_start |-> source_on)
      else $error("conversion without source");
   step_x4_a: assert property (source_on && $past(source_on)
      && source_current_idx != $past(source_current_idx)
      |-> source_current_idx == $past(source_current_idx) + 2'h1)
      else $error("current step skipped");
   conv_chain_a: assert property (adc_done && source_on |-> ##[1:8] (adc_start || !source_on))
      else $error("measurement stalled");
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside read");
endmodule // plc_props

bind plc_attach_moisture_detect plc_props #(.PULSE_CYC(PULSE_CYC)) i_props (
   .mclk(mclk), .rst(rst), .link_up(link_up), .rd(rd), .rdata(rdata), .pulse_fire(pulse_fire),
   .adc_start(adc_start), .adc_done(adc_done), .source_on(source_on),
   .source_current_idx(source_current_idx));

// file: front_model.sv
// Purpose: pulse comparator and adc seen from the contact, counterpart side
// Assumes: bench sets the line load through reduced, lvl and spread
// Notes: adc data toggles between conversions so stale codes never look valid
`timescale 1ns/100ps
module front_model (
   // clock and line load
   input wire mclk,
   input wire reduced,
   input wire spread,
   input wire [23:0] lvl,
   // detection front end
   input wire pulse_fire,
   output reg pulse_done_in,
   output reg pulse_reduced_in,
   // adc
   input wire adc_start,
   input wire [1:0] source_current_idx,
   output reg adc_done,
   output reg [5:0] adc_data
);
   // counterpart retry and periodic bits act only on its own side
   integer pc = 0;
   integer ac = 0;
   reg odd = 1'b0;
   initial
   begin
      pulse_done_in = 1'b0;
      pulse_reduced_in = 1'b0;
      adc_done = 1'b0;
      adc_data = 6'h00;
   end
   // level settles first, result edge later, held five cycles
   always @(posedge mclk)
   begin
      if (pulse_fire)
         pc <= 1;
      else if (pc != 0)
         pc <= (pc == 10) ? 0 : pc + 1;
      if (pc == 2)
         pulse_reduced_in <= reduced;
      pulse_done_in <= (pc >= 5 && pc <= 9);
   end
   // conversion answers three cycles after start
   always @(posedge mclk)
   begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_start)
         ac <= 3;
      else if (ac != 0)
         ac <= ac - 1;
      if (ac == 1)
      begin
         adc_done <= 1'b1;
         adc_data <= lvl[6*source_current_idx +: 6] + ((spread && odd) ? 6'h0c : 6'h00);
         odd <= ~odd;
      end
   end
endmodule // front_model

// file: tb.sv
// Purpose: self-checking bench for the attach and wet measurement sequencer
// Assumes: short timing parameters; ce held high
// Notes: range 0x20 and a 40 mV code make every result class reachable
`timescale 1ns/100ps
`include "plc_defs.vh"
module tb;
   localparam [31:0] PULSE = 32'd200;
   localparam [31:0] POWER = 32'd500;
   localparam [31:0] AUTO = 32'd20000;
   localparam [31:0] ALL = 32'hffffffff;
   localparam [23:0] WET = {6'd40, 6'd20, 6'd10, 6'd5};
   reg mclk, rst, wr, rd, line_power_in, link_up, reduced, spread;
   reg [7:0] addr;
   reg [31:0] wdata;
   reg [23:0] lvl;
   wire [31:0] rdata;
   wire [5:0] adc_data;
   wire [1:0] source_current_idx;
   wire pulse_fire, pulse_done_in, pulse_reduced_in, adc_start, source_on, adc_done;
   integer mismatches = 0;
   integer n_tests = 0;
   integer cyc = 0;

   plc_attach_moisture_detect #(.PULSE_CYC(PULSE), .POWER_CYC(POWER), .AUTO_CYC(AUTO),
      .LSB_UV(20'd40000)) i_dut (
      .mclk(mclk), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .pulse_fire(pulse_fire), .pulse_done_in(pulse_done_in),
      .pulse_reduced_in(pulse_reduced_in), .line_power_in(line_power_in), .link_up(link_up),
      .adc_start(adc_start), .source_current_idx(source_current_idx), .source_on(source_on),
      .adc_done(adc_done), .adc_data(adc_data));
   front_model i_front (
      .mclk(mclk), .reduced(reduced), .spread(spread), .lvl(lvl), .pulse_fire(pulse_fire),
      .pulse_done_in(pulse_done_in), .pulse_reduced_in(pulse_reduced_in),
      .adc_start(adc_start), .source_current_idx(source_current_idx),
      .adc_done(adc_done), .adc_data(adc_data));

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // hang guard, well past the periodic retry
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         $display("unexpected timeout at %0t", $time);
         mismatches = mismatches + 1;
         conclude;
      end
   end
   // -----------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------
   task conclude;
   begin
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
         mismatches = mismatches + 1;
      end
   end
   endtask
   task wreg(input [7:0] a, input [31:0] v);
   begin
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   end
   endtask
   // data stand only in the cycle after the strobe
   task rreg(input [7:0] a, input [31:0] m, input [31:0] e);
   begin
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      chk(rdata & m, e);
   end
   endtask
   // bounded wait for a whole measurement
   task wait_meas(input integer lim);
      integer i;
   begin
      i = 0;
      while (source_on !== 1'b1 && i < lim)
      begin
         @(posedge mclk);
         #1;
         i = i + 1;
      end
      chk({31'h0, source_on}, 32'h1);
      i = 0;
      while (source_on !== 1'b0 && i < 400)
      begin
         @(posedge mclk);
         #1;
         i = i + 1;
      end
      chk({31'h0, source_on}, 32'h0);
      repeat (3) @(posedge mclk);
   end
   endtask
   task run_case(input [23:0] lv, input sp, input [31:0] ef, input [31:0] rm, input [31:0] er);
   begin
      wreg(`REG_FLAGS, 32'h7f);
      lvl <= lv;
      spread <= sp;
      wreg(`REG_CTRL, 32'h1);
      wait_meas(20);
      rreg(`REG_FLAGS, 32'h7c, ef);
      rreg(`REG_RESULT, rm, er);
   end
   endtask
   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   // reset values, unmapped and read-only places
   task t_registers;
   begin
      rreg(`REG_CONFIG, ALL, 32'h000002bc);
      rreg(`REG_FLAGS, ALL, 32'h0);
      rreg(8'h14, ALL, 32'h0);
      wreg(`REG_CONFIG, 32'h200002bc);
      rreg(`REG_CONFIG, ALL, 32'h200002bc);
      wreg(`REG_RESULT, ALL);
      rreg(`REG_RESULT, ALL, 32'h0);
      $display("registers done");
   end
   endtask
   // three reduced pulses, then no line power
   task t_dead;
   begin
      reduced <= 1'b1;
      wait_meas(4 * PULSE + 100);
      rreg(`REG_FLAGS, 32'h0e, 32'h0a);
      rreg(`REG_RESULT, ALL, 32'h4028);
      wait_meas(POWER + 100);
      $display("dead counterpart done");
   end
   endtask
   // done, open, stepped wet, ground short, abort
   task t_classes;
   begin
      run_case(24'd31, 1'b0, 32'h10, ALL, 32'h011f);
      run_case(24'd63, 1'b0, 32'h20, ALL, 32'h013f);
      run_case(WET, 1'b0, 32'h08, ALL, 32'h4028);
      run_case(24'd0, 1'b0, 32'h0c, ALL, 32'h4000);
      run_case(24'd20, 1'b1, 32'h40, 32'h0, 32'h0);
      $display("classes done");
   end
   endtask
   // wet cleared by a full pulse, count restarts
   task t_wet_clear;
   begin
      run_case(WET, 1'b0, 32'h08, ALL, 32'h4028);
      @(posedge mclk);
      reduced <= 1'b0;
      line_power_in <= 1'b1;
      repeat (PULSE + 20) @(posedge mclk);
      rreg(`REG_FLAGS, 32'h08, 32'h0);
      rreg(`REG_STATUS, 32'h08, 32'h0);
      wreg(`REG_FLAGS, 32'h7f);
      reduced <= 1'b1;
      wait_meas(4 * PULSE + 100);
      rreg(`REG_FLAGS, 32'h02, 32'h02);
      $display("wet clear done");
   end
   endtask
   // manual request held back by the link
   task t_link_hold;
   begin
      wreg(`REG_FLAGS, 32'h7f);
      link_up <= 1'b1;
      repeat (5) @(posedge mclk);
      rreg(`REG_FLAGS, 32'h01, 32'h01);
      wreg(`REG_CTRL, 32'h1);
      rreg(`REG_STATUS, 32'h07, 32'h05);
      repeat (50) @(posedge mclk);
      #1;
      chk({31'h0, source_on}, 32'h0);
      @(posedge mclk);
      link_up <= 1'b0;
      wait_meas(20);
      rreg(`REG_STATUS, 32'h04, 32'h0);
      $display("link hold done");
   end
   endtask
   // periodic retry runs without any setting
   task t_periodic;
   begin
      lvl <= 24'd31;
      wreg(`REG_FLAGS, 32'h7f);
      wait_meas(AUTO + 100);
      rreg(`REG_FLAGS, 32'h7c, 32'h10);
      $display("periodic done");
   end
   endtask
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial
   begin
      {rst, wr, rd, line_power_in, link_up, reduced, spread} = 7'h40;
      addr = 8'h00;
      wdata = 32'h0;
      lvl = WET;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      t_registers;
      t_dead;
      t_classes;
      t_wet_clear;
      t_link_hold;
      t_periodic;
      conclude;
   end
endmodule // tb
